/* rtl/eevc_map.svh */
// register offsets, field positions, reset values and sizes of the edge event controller
`ifndef EEVC_MAP_SVH
`define EEVC_MAP_SVH

`define EEVC_NUM_LINES 19
`define EEVC_NUM_EXT 16
`define EEVC_NUM_PINS 80
`define EEVC_SEL_W 7
`define EEVC_ADDR_W 8

`define EEVC_LINE_SUPPLY 16
`define EEVC_LINE_RTC 17
`define EEVC_LINE_USB 18

`define EEVC_OFF_IMASK 8'h00
`define EEVC_OFF_EMASK 8'h04
`define EEVC_OFF_RISE 8'h08
`define EEVC_OFF_FALL 8'h0c
`define EEVC_OFF_SWTRIG 8'h10
`define EEVC_OFF_PEND 8'h14
`define EEVC_SEL_BLK 4'h2
`define EEVC_SEL_PER_REG 4
`define EEVC_SEL_FIELD 8

`define EEVC_LINES_RST 19'h00000
`define EEVC_SEL_RST 7'h00
`define EEVC_WORD_RST 32'h00000000

`endif

/* rtl/eevc_pkg.sv */
// types shared by the edge event controller
`include "eevc_map.svh"

package eevc_pkg;

    typedef logic [`EEVC_NUM_LINES-1:0] eevc_lines_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [`EEVC_ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } eevc_apb_req_s;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } eevc_apb_rsp_s;

    typedef struct packed {
        eevc_lines_t imask;
        eevc_lines_t emask;
        eevc_lines_t rise_en;
        eevc_lines_t fall_en;
        eevc_lines_t pend;
        logic [`EEVC_NUM_EXT-1:0][`EEVC_SEL_W-1:0] pin_sel;
        eevc_lines_t rise_s1;
        eevc_lines_t rise_s2;
        eevc_lines_t rise_s3;
        eevc_lines_t fall_s1;
        eevc_lines_t fall_s2;
        eevc_lines_t fall_s3;
        eevc_lines_t irq;
        eevc_lines_t evt;
        logic wake;
        eevc_apb_rsp_s rsp;
    } eevc_state_s;

endpackage : eevc_pkg

/* rtl/eevc_edge_cell.sv */
// edge capture cell clocked by the line itself, so it needs no bus clock
`timescale 1ns/10ps
`default_nettype none

module eevc_edge_cell (
    input wire logic line_in,
    input wire logic presetn,
    input wire logic rise_en,
    input wire logic fall_en,
    output logic rise_tgl,
    output logic fall_tgl
);

    // short pulses caught
    // the line edge clocks the flop, so pulse width is not bounded by pclk
    always_ff @(posedge line_in or negedge presetn)
    begin
        if (!presetn)
            rise_tgl <= 1'b0;
        else if (rise_en)
            rise_tgl <= ~rise_tgl;
    end

    // works without clock
    // toggles hold the edge while pclk is stopped
    always_ff @(negedge line_in or negedge presetn)
    begin
        if (!presetn)
            fall_tgl <= 1'b0;
        else if (fall_en)
            fall_tgl <= ~fall_tgl;
    end

endmodule : eevc_edge_cell

`default_nettype wire

/* rtl/eevc_ctrl.sv */
// edge event and wakeup controller: line routing, pending state, APB registers
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "eevc_map.svh"

module eevc_ctrl (
    input wire logic pclk,
    input wire logic presetn,
    input wire eevc_pkg::eevc_apb_req_s apb_req,
    output eevc_pkg::eevc_apb_rsp_s apb_rsp,
    input wire logic [`EEVC_NUM_PINS-1:0] gpio_pins,
    input wire logic supply_threshold_monitor,
    input wire logic rtc_alarm,
    input wire logic usb_wakeup,
    output eevc_pkg::eevc_lines_t irq_req,
    output eevc_pkg::eevc_lines_t evt_pulse,
    output logic wake_req
);

    eevc_pkg::eevc_state_s st_reg;
    eevc_pkg::eevc_state_s st_next;
    eevc_pkg::eevc_lines_t line_in;
    eevc_pkg::eevc_lines_t rise_tgl;
    eevc_pkg::eevc_lines_t fall_tgl;
    eevc_pkg::eevc_lines_t edge_ev;
    eevc_pkg::eevc_lines_t sw_ev;
    eevc_pkg::eevc_lines_t clr_mask;
    logic access;
    logic wr_done;
    logic sel_hit;
    logic [1:0] sel_idx;
    logic hit_q;

    genvar gi;
    generate
        for (gi = 0; gi < `EEVC_NUM_LINES; gi++)
        begin : g_line
            if (gi < `EEVC_NUM_EXT)
            begin : g_pin
                // pin routing mux
                // out-of-range selects read as a quiet line
                assign line_in[gi] = (st_reg.pin_sel[gi] < `EEVC_SEL_W'(`EEVC_NUM_PINS))
                    ? gpio_pins[st_reg.pin_sel[gi]] : 1'b0;
            end
            else if (gi == `EEVC_LINE_SUPPLY)
            begin : g_sup
                assign line_in[gi] = supply_threshold_monitor;
            end
            else if (gi == `EEVC_LINE_RTC)
            begin : g_rtc
                assign line_in[gi] = rtc_alarm;
            end
            else
            begin : g_usb
                assign line_in[gi] = usb_wakeup;
            end
            eevc_edge_cell u_cell (
                .line_in(line_in[gi]),
                .presetn(presetn),
                .rise_en(st_reg.rise_en[gi]),
                .fall_en(st_reg.fall_en[gi]),
                .rise_tgl(rise_tgl[gi]),
                .fall_tgl(fall_tgl[gi])
            );
        end
    endgenerate

    function automatic logic [31:0] read_word(
        input eevc_pkg::eevc_state_s s,
        input logic [`EEVC_ADDR_W-1:0] addr,
        output logic hit
    );
        logic [31:0] w;
        w = `EEVC_WORD_RST;
        hit = 1'b1;
        if (addr[7:4] == `EEVC_SEL_BLK)
        begin
            for (int j = 0; j < `EEVC_SEL_PER_REG; j++)
                w[j*`EEVC_SEL_FIELD +: `EEVC_SEL_W] =
                    s.pin_sel[{addr[3:2], 2'(j)}];
        end
        else
        begin
            case (addr)
                `EEVC_OFF_IMASK: w[`EEVC_NUM_LINES-1:0] = s.imask;
                `EEVC_OFF_EMASK: w[`EEVC_NUM_LINES-1:0] = s.emask;
                `EEVC_OFF_RISE: w[`EEVC_NUM_LINES-1:0] = s.rise_en;
                `EEVC_OFF_FALL: w[`EEVC_NUM_LINES-1:0] = s.fall_en;
                `EEVC_OFF_SWTRIG: w = `EEVC_WORD_RST;
                `EEVC_OFF_PEND: w[`EEVC_NUM_LINES-1:0] = s.pend;
                default: hit = 1'b0;
            endcase
        end
        return w;
    endfunction : read_word

    always_comb
    begin
        logic [31:0] rd;
        logic hit;
        rd = `EEVC_WORD_RST;
        hit = 1'b0;
        st_next = st_reg;
        access = apb_req.psel & apb_req.penable;
        wr_done = access & st_reg.rsp.pready & apb_req.pwrite;
        sel_hit = apb_req.paddr[7:4] == `EEVC_SEL_BLK;
        sel_idx = apb_req.paddr[3:2];
        sw_ev = `EEVC_LINES_RST;
        clr_mask = `EEVC_LINES_RST;

        // toggles cross into pclk through two flops, the third finds the change
        st_next.rise_s1 = rise_tgl;
        st_next.rise_s2 = st_reg.rise_s1;
        st_next.rise_s3 = st_reg.rise_s2;
        st_next.fall_s1 = fall_tgl;
        st_next.fall_s2 = st_reg.fall_s1;
        st_next.fall_s3 = st_reg.fall_s2;
        edge_ev = (st_reg.rise_s2 ^ st_reg.rise_s3) | (st_reg.fall_s2 ^ st_reg.fall_s3);

        if (wr_done)
        begin
            if (sel_hit)
            begin
                for (int j = 0; j < `EEVC_SEL_PER_REG; j++)
                    st_next.pin_sel[{sel_idx, 2'(j)}] =
                        apb_req.pwdata[j*`EEVC_SEL_FIELD +: `EEVC_SEL_W];
            end
            else
            begin
                case (apb_req.paddr)
                    `EEVC_OFF_IMASK: st_next.imask = apb_req.pwdata[`EEVC_NUM_LINES-1:0];
                    `EEVC_OFF_EMASK: st_next.emask = apb_req.pwdata[`EEVC_NUM_LINES-1:0];
                    `EEVC_OFF_RISE: st_next.rise_en = apb_req.pwdata[`EEVC_NUM_LINES-1:0];
                    `EEVC_OFF_FALL: st_next.fall_en = apb_req.pwdata[`EEVC_NUM_LINES-1:0];
                    `EEVC_OFF_SWTRIG: sw_ev = apb_req.pwdata[`EEVC_NUM_LINES-1:0];
                    `EEVC_OFF_PEND: clr_mask = apb_req.pwdata[`EEVC_NUM_LINES-1:0];
                    default: clr_mask = `EEVC_LINES_RST;
                endcase
            end
        end

        st_next.pend = (st_reg.pend & ~clr_mask) | ((edge_ev | sw_ev) & st_reg.imask);
        st_next.irq = st_next.pend & st_next.imask;
        st_next.evt = (edge_ev | sw_ev) & st_reg.emask;
        st_next.wake = (|st_next.irq) | (|st_next.evt);

        // one wait state: data is ready when pready is first seen high
        if (access && !st_reg.rsp.pready)
        begin
            rd = read_word(st_reg, apb_req.paddr, hit);
            st_next.rsp.pready = 1'b1;
            st_next.rsp.pslverr = ~hit;
            st_next.rsp.prdata = apb_req.pwrite ? `EEVC_WORD_RST : rd;
        end
        else
        begin
            st_next.rsp.pready = 1'b0;
            st_next.rsp.pslverr = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign apb_rsp = st_reg.rsp;
    assign irq_req = st_reg.irq;
    assign evt_pulse = st_reg.evt;
    assign wake_req = st_reg.wake;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_setup;
        apb_req.psel && !apb_req.penable;
    endsequence

    sequence s_wait_then_ready;
        !apb_rsp.pready ##1 apb_rsp.pready;
    endsequence

    AST_APB_ONE_WAIT: assert property (s_setup ##1 access |-> s_wait_then_ready)
        else $error("apb answer not after exactly one wait state");

    AST_PEND_SET: assert property (|(edge_ev & st_reg.imask)
        |=> ((st_reg.pend & $past(edge_ev & st_reg.imask)) == $past(edge_ev & st_reg.imask)))
        else $error("unmasked edge did not set pending");

    AST_PEND_HOLD: assert property (!wr_done |=> (st_reg.pend & $past(st_reg.pend)) ==
        $past(st_reg.pend))
        else $error("pending bit dropped without a clear write");

    AST_PEND_CLR: assert property (|clr_mask && !(|edge_ev) && !(|sw_ev)
        |=> (st_reg.pend & $past(clr_mask)) == '0)
        else $error("write one did not clear pending");

    AST_MASK_BLOCK: assert property (|(edge_ev & ~st_reg.imask & ~st_reg.pend)
        && !wr_done |=> (st_reg.pend & $past(edge_ev & ~st_reg.imask & ~st_reg.pend)) == '0)
        else $error("masked edge set pending");

    AST_IRQ_ONLY_UNMASKED: assert property ((irq_req & ~st_reg.imask) == '0)
        else $error("interrupt raised on masked line");

    AST_EVT_PULSE: assert property (|(edge_ev & st_reg.emask) && !wr_done
        |=> (evt_pulse == $past(edge_ev & st_reg.emask)) && wake_req)
        else $error("event pulse missing or not joined by wake");

    AST_WAKE: assert property (|(edge_ev & (st_reg.imask | st_reg.emask)) |-> ##[1:2] wake_req)
        else $error("request did not raise wake within two cycles");

    AST_SYNC_LAT: assert property ($changed(st_reg.rise_s2) |-> (|edge_ev))
        else $error("captured edge not seen after synchroniser");

    AST_SLVERR: assert property (apb_rsp.pready && $past(!hit_q) |-> apb_rsp.pslverr)
        else $error("unmapped access not flagged");

    always_comb
    begin
        logic [31:0] dummy;
        dummy = read_word(st_reg, apb_req.paddr, hit_q);
    end

endmodule : eevc_ctrl

`default_nettype wire

/* test/eevc_core_model.sv */
// far-side model: counts event pulses and wake requests
`timescale 1ns/10ps
`default_nettype none
module eevc_core_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire eevc_pkg::eevc_lines_t evt_pulse,
    input wire logic wake_req,
    output int evt_cnt,
    output int wake_cnt
);
    logic wake_d;
    // wake counts rises only, so a held request counts once; events count every pulse bit
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            evt_cnt <= 0;
            wake_cnt <= 0;
            wake_d <= 1'b0;
        end
        else
        begin
            evt_cnt <= evt_cnt + $countones(evt_pulse);
            wake_cnt <= wake_cnt + int'(wake_req & ~wake_d);
            wake_d <= wake_req;
        end
    end
endmodule : eevc_core_model
`default_nettype wire

/* test/test_eevc_ctrl.sv */
// self-checking bench for the edge event controller
`timescale 1ns/10ps
`default_nettype none
module test_eevc_ctrl;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    eevc_pkg::eevc_apb_req_s req = '0;
    eevc_pkg::eevc_apb_rsp_s rsp;
    logic [79:0] pins = '0;
    logic [2:0] src = '0;
    eevc_pkg::eevc_lines_t irq_req;
    eevc_pkg::eevc_lines_t evt_pulse;
    logic wake_req;
    int evt_cnt, wake_cnt, c0, k, p, m;
    int miscompares = 0;
    int cmp_count = 0;
    int seed = 67;
    logic [31:0] rd, d;
    logic err;
    always #5 pclk = ~pclk;
    eevc_ctrl eevc_ctrl_i (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
        .gpio_pins(pins), .supply_threshold_monitor(src[0]), .rtc_alarm(src[1]),
        .usb_wakeup(src[2]), .irq_req(irq_req), .evt_pulse(evt_pulse), .wake_req(wake_req));
    eevc_core_model eevc_core_model_i (.pclk(pclk), .presetn(presetn),
        .evt_pulse(evt_pulse), .wake_req(wake_req), .evt_cnt(evt_cnt), .wake_cnt(wake_cnt));
    task give_verdict;
        if (miscompares == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict
    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
        @(posedge pclk);
        req.penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (rsp.pready !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            miscompares++;
            give_verdict();
        end
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
    endtask : apb
    // lines 0..15 come through the pin selects, 16..18 are internal
    task put(input int k, input logic v);
        if (k < 16)
            pins[k] <= v;
        else
            src[k-16] <= v;
    endtask : put
    task drive(input int k, input logic v);
        @(posedge pclk);
        put(k, v);
    endtask : drive
    task pend_is(input logic [31:0] exp);
        repeat (6) @(posedge pclk);
        apb(1'b0, 8'h14, 32'h0);
        chk("pending", rd, exp);
    endtask : pend_is
    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 12; i++)
        begin
            apb(1'b0, 8'(i * 4), 32'h0);
            chk("slverr", 32'(err), 32'(i == 6 || i == 7));
            chk("reset value", rd, 32'h0);
        end
        for (int i = 0; i < 4; i++)
        begin
            d = $random(seed);
            apb(1'b1, 8'(i * 4), d);
            apb(1'b0, 8'(i * 4), 32'h0);
            chk("config readback", rd, d & 32'h7ffff);
            apb(1'b1, 8'(32 + i * 4), {8'(4*i+3), 8'(4*i+2), 8'(4*i+1), 8'(4*i)});
        end
        for (m = 0; m < 3; m++)
        begin
            k = $unsigned($random(seed)) % 19;
            apb(1'b1, 8'h00, 32'h7ffff);
            apb(1'b1, 8'h04, 32'h1 << k);
            apb(1'b1, 8'h08, 32'(m != 1) << k);
            apb(1'b1, 8'h0c, 32'(m != 0) << k);
            c0 = evt_cnt;
            drive(k, 1'b1);
            pend_is(32'(m != 1) << k);
            chk("irq", 32'(irq_req), 32'(m != 1) << k);
            chk("events", 32'(evt_cnt - c0), 32'(m != 1));
            apb(1'b1, 8'h14, 32'h7ffff);
            pend_is(32'h0);
            drive(k, 1'b0);
            pend_is(32'(m != 0) << k);
            apb(1'b1, 8'h14, 32'h7ffff);
            pend_is(32'h0);
        end
        // masked line with both edges on
        apb(1'b1, 8'h00, 32'h7ffff ^ (32'h1 << k));
        apb(1'b1, 8'h08, 32'h1 << k);
        drive(k, 1'b1);
        drive(k, 1'b0);
        pend_is(32'h0);
        chk("masked irq", 32'(irq_req), 32'h0);
        // sub-period pulse on the supply line, falling edge only
        apb(1'b1, 8'h00, 32'h7ffff);
        apb(1'b1, 8'h08, 32'h0);
        apb(1'b1, 8'h0c, 32'h10000);
        c0 = wake_cnt;
        @(posedge pclk);
        #2 src[0] = 1'b1;
        #3 src[0] = 1'b0;
        pend_is(32'h10000);
        chk("wakeups", 32'(wake_cnt - c0), 32'h1);
        apb(1'b1, 8'h14, 32'h7ffff);
        p = $unsigned($random(seed)) % 80;
        k = $unsigned($random(seed)) % 16;
        d = 32'h7f7f7f7f;
        d[8 * (k % 4) +: 8] = 8'(p);
        apb(1'b1, 8'(32 + 4 * (k / 4)), d);
        apb(1'b1, 8'h08, 32'h1 << k);
        apb(1'b1, 8'h0c, 32'h0);
        @(posedge pclk);
        #2 pins[p] = 1'b1;
        #3 pins[p] = 1'b0;
        pend_is(32'h1 << k);
        // software trigger acts like an edge on every enabled mask
        apb(1'b1, 8'h14, 32'h7ffff);
        apb(1'b1, 8'h04, 32'h7ffff);
        c0 = evt_cnt;
        apb(1'b1, 8'h10, 32'h1 << k);
        pend_is(32'h1 << k);
        chk("sw events", 32'(evt_cnt - c0), 32'h1);
        give_verdict();
    end
endmodule : test_eevc_ctrl
`default_nettype wire
